// ===== logic/ufc_defines.svh
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// Register byte offsets
`define UFC_OFS_STATUS 8'h00
`define UFC_OFS_CONTROL 8'h04

// Control field positions and reset value
`define UFC_FCR_ENABLE 0
`define UFC_FCR_RX_FLUSH 1
`define UFC_FCR_TX_FLUSH 2
`define UFC_FCR_RESET 8'h00

// Interrupt source codes, bits 3..0
`define UFC_CODE_LINE 4'h6
`define UFC_CODE_RX_DATA 4'h4
`define UFC_CODE_RX_TMO 4'hC
`define UFC_CODE_THR 4'h2
`define UFC_CODE_MODEM 4'h0
`define UFC_CODE_NONE 4'h1

// Receive trigger levels and FIFO depths in bytes
`define UFC_TRIG16_0 7'h01
`define UFC_TRIG16_1 7'h04
`define UFC_TRIG16_2 7'h08
`define UFC_TRIG16_3 7'h0E
`define UFC_TRIG64_0 7'h01
`define UFC_TRIG64_1 7'h10
`define UFC_TRIG64_2 7'h20
`define UFC_TRIG64_3 7'h38
`define UFC_DEPTH16 7'h10
`define UFC_DEPTH64 7'h40

// Bus responses
`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_SLVERR 2'h2

`endif

// ===== logic/ufc_pkg.sv
package ufc_pkg;

    // FIFO control register layout
    typedef struct packed {
        logic [1:0] rx_threshold_select;
        logic depth64;
        logic reserved;
        logic dma_block;
        logic tx_fifo_flush;
        logic rx_fifo_flush;
        logic enable;
    } ufc_fcr_t;

    // Event pulses from the rest of the UART
    typedef struct packed {
        logic line_status;
        logic rx_timeout;
        logic tx_holding_empty;
        logic modem_status;
    } ufc_evt_t;

    // Pending interrupt flags
    typedef struct packed {
        logic line_status;
        logic rx_data;
        logic rx_timeout;
        logic tx_holding;
        logic modem_status;
    } ufc_pend_t;

    // Register select from address decode
    typedef enum logic [1:0] {
        UFC_SEL_NONE = 2'b00,
        UFC_SEL_STATUS = 2'b01,
        UFC_SEL_CONTROL = 2'b10
    } ufc_sel_t;

endpackage

// ===== logic/ufc_top.sv
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ufc_defines.svh"

module ufc_top #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 7,
    parameter logic [6:0] TX_TRIGGER = 7'h08
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CNT_W-1:0] tx_fifo_count,
    input wire logic [CNT_W-1:0] rx_fifo_count,
    input wire logic tx_path_empty,
    input wire ufc_pkg::ufc_evt_t events,
    output ufc_pkg::ufc_fcr_t fifo_control_q,
    output logic [CNT_W-1:0] rx_trigger_level_q,
    output logic tx_dma_request_n_q,
    output logic rx_dma_request_n_q
);
    import ufc_pkg::*;

    // Elaboration checks
    if (ADDR_W < 8) begin : g_chk_addr
        $error("ADDR_W must be at least 8");
    end
    if (CNT_W != 7) begin : g_chk_cnt
        $error("CNT_W must be 7 to count 64 bytes");
    end
    if (TX_TRIGGER == 7'h00 || TX_TRIGGER > `UFC_DEPTH64) begin : g_chk_trig
        $error("TX_TRIGGER out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address decode, shared by both bus directions
    function automatic ufc_sel_t decode(input logic [ADDR_W-1:0] addr);
        if (addr == ADDR_W'(`UFC_OFS_STATUS)) begin
            return UFC_SEL_STATUS;
        end else if (addr == ADDR_W'(`UFC_OFS_CONTROL)) begin
            return UFC_SEL_CONTROL;
        end
        return UFC_SEL_NONE;
    endfunction

    // Priority encoder for pending interrupts
    function automatic logic [3:0] int_code(input ufc_pend_t p);
        if (p.line_status) begin
            return `UFC_CODE_LINE;
        end else if (p.rx_data) begin
            return `UFC_CODE_RX_DATA;
        end else if (p.rx_timeout) begin
            return `UFC_CODE_RX_TMO;
        end else if (p.tx_holding) begin
            return `UFC_CODE_THR;
        end else if (p.modem_status) begin
            return `UFC_CODE_MODEM;
        end
        return `UFC_CODE_NONE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic aw_hs, w_hs, ar_hs, do_wr;
    logic aw_got_q, w_got_q, aw_got_d, w_got_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    ufc_sel_t wr_sel, rd_sel;
    logic [3:0] code_w;
    logic [7:0] status_w;
    ufc_pend_t pend_q, pend_set, pend_clr;
    logic status_rd;
    logic [CNT_W-1:0] trig_w, depth_w;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign aw_got_d = (aw_got_q | aw_hs) & ~do_wr;
    assign w_got_d = (w_got_q | w_hs) & ~do_wr;
    assign wr_sel = decode(awaddr_q);
    assign rd_sel = decode(s_axi_araddr);

    // Address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            s_axi_awready <= ~aw_got_d;
            s_axi_wready <= ~w_got_d;
        end
    end

    // Write payload capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UFC_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == UFC_SEL_NONE) ? `UFC_RESP_SLVERR : `UFC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel, data captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UFC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~(ar_hs | (s_axi_rvalid & ~s_axi_rready));
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (rd_sel == UFC_SEL_NONE) ? `UFC_RESP_SLVERR : `UFC_RESP_OKAY;
                unique case (rd_sel)
                    UFC_SEL_STATUS: s_axi_rdata <= {24'h00_0000, status_w};
                    UFC_SEL_CONTROL: s_axi_rdata <= {24'h00_0000, fifo_control_q};
                    UFC_SEL_NONE: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // FIFO control register

    // Writes without the enable bit only clear the enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_control_q <= `UFC_FCR_RESET;
        end else begin
            fifo_control_q.tx_fifo_flush <= 1'b0;
            fifo_control_q.rx_fifo_flush <= 1'b0;
            if (do_wr && wr_sel == UFC_SEL_CONTROL && wstrb_q[0]) begin
                fifo_control_q.enable <= wdata_q[`UFC_FCR_ENABLE];
                if (wdata_q[`UFC_FCR_ENABLE]) begin
                    fifo_control_q <= ufc_fcr_t'(wdata_q[7:0]);
                    fifo_control_q.reserved <= 1'b0;
                end
            end
        end
    end

    // Trigger level and depth lookup
    always_comb begin
        unique case ({fifo_control_q.depth64, fifo_control_q.rx_threshold_select})
            3'b000: trig_w = `UFC_TRIG16_0;
            3'b001: trig_w = `UFC_TRIG16_1;
            3'b010: trig_w = `UFC_TRIG16_2;
            3'b011: trig_w = `UFC_TRIG16_3;
            3'b100: trig_w = `UFC_TRIG64_0;
            3'b101: trig_w = `UFC_TRIG64_1;
            3'b110: trig_w = `UFC_TRIG64_2;
            3'b111: trig_w = `UFC_TRIG64_3;
        endcase
        if (!fifo_control_q.enable) begin
            trig_w = `UFC_TRIG16_0;
        end
        depth_w = fifo_control_q.depth64 ? `UFC_DEPTH64 : `UFC_DEPTH16;
    end

    // Registered trigger level for the receive path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_trigger_level_q <= `UFC_TRIG16_0;
        end else begin
            rx_trigger_level_q <= trig_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA request pins

    logic blk_mode;
    assign blk_mode = fifo_control_q.enable & fifo_control_q.dma_block;

    // Transmit request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_dma_request_n_q <= 1'b0;
        end else if (!blk_mode) begin
            tx_dma_request_n_q <= ~tx_path_empty;
        end else if (tx_fifo_count >= depth_w) begin
            tx_dma_request_n_q <= 1'b1;
        end else if (tx_fifo_count <= TX_TRIGGER) begin
            tx_dma_request_n_q <= 1'b0;
        end
    end

    // Receive request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_dma_request_n_q <= 1'b1;
        end else if (!blk_mode) begin
            rx_dma_request_n_q <= (rx_fifo_count == '0);
        end else if (rx_fifo_count >= trig_w || events.rx_timeout) begin
            rx_dma_request_n_q <= 1'b0;
        end else if (rx_fifo_count == '0) begin
            rx_dma_request_n_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status

    assign code_w = int_code(pend_q);
    assign status_rd = ar_hs & (rd_sel == UFC_SEL_STATUS);
    assign status_w = {{2{fifo_control_q.enable}},
                       fifo_control_q.enable & fifo_control_q.depth64,
                       1'b0,
                       code_w};

    // Set and clear terms; a new event beats a read clear
    always_comb begin
        pend_set.line_status = events.line_status;
        pend_set.rx_data = (rx_fifo_count == trig_w);
        pend_set.rx_timeout = events.rx_timeout;
        pend_set.tx_holding = events.tx_holding_empty;
        pend_set.modem_status = events.modem_status;
        pend_clr.line_status = status_rd && code_w == `UFC_CODE_LINE;
        pend_clr.rx_data = (status_rd && code_w == `UFC_CODE_RX_DATA) || rx_fifo_count < trig_w;
        pend_clr.rx_timeout = status_rd && code_w == `UFC_CODE_RX_TMO;
        pend_clr.tx_holding = status_rd && code_w == `UFC_CODE_THR;
        pend_clr.modem_status = status_rd && code_w == `UFC_CODE_MODEM;
    end

    // Pending flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | pend_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_ctl_write(bit en);
        do_wr && wr_sel == UFC_SEL_CONTROL && wstrb_q[0] && wdata_q[0] == en;
    endsequence

    a_tx_flush_pulse: assert property (s_ctl_write(1'b1) ##0 wdata_q[2] |=>
        fifo_control_q.tx_fifo_flush ##1 !fifo_control_q.tx_fifo_flush)
        else $error("transmit flush not a single pulse");

    a_rx_flush_pulse: assert property (s_ctl_write(1'b1) ##0 wdata_q[1] |=>
        fifo_control_q.rx_fifo_flush ##1 !fifo_control_q.rx_fifo_flush)
        else $error("receive flush not a single pulse");

    a_fields_locked: assert property (s_ctl_write(1'b0) |=>
        !fifo_control_q.enable && fifo_control_q[7:3] == $past(fifo_control_q[7:3]))
        else $error("control fields changed without enable");

    a_enable_set: assert property (s_ctl_write(1'b1) |=> fifo_control_q.enable &&
        fifo_control_q.rx_threshold_select == $past(wdata_q[7:6]))
        else $error("enable write not stored");

    a_trig_table: assert property (fifo_control_q.enable && fifo_control_q.depth64 &&
        fifo_control_q.rx_threshold_select == 2'b11 |-> trig_w == 7'h38)
        else $error("64-byte top trigger wrong");

    a_line_first: assert property (pend_q.line_status |-> status_w[3:0] == 4'h6)
        else $error("line status not top priority");

    a_rx_over_thr: assert property (!pend_q.line_status && pend_q.rx_data |->
        status_w[3:0] == 4'h4)
        else $error("receive data code wrong");

    a_thr_code: assert property (pend_q[4:2] == 3'b000 && pend_q.tx_holding |->
        status_w[3:0] == 4'h2)
        else $error("transmit empty code wrong");

    a_read_clears: assert property (status_rd && code_w == 4'h6 && !events.line_status |=>
        !pend_q.line_status && s_axi_rdata[3:0] == 4'h6)
        else $error("reported interrupt not cleared by read");

    a_low_kept: assert property (status_rd && code_w == 4'h6 && pend_q.modem_status |=>
        pend_q.modem_status)
        else $error("lower interrupt lost on read");

    a_status_top: assert property (status_rd |=> s_axi_rdata[7:4] ==
        {{2{$past(fifo_control_q.enable)}}, $past(fifo_control_q.enable & fifo_control_q.depth64), 1'b0})
        else $error("status upper bits wrong");

    a_idle_bit: assert property ((pend_q == '0) == status_w[0])
        else $error("pending bit wrong");

    a_tx_full_high: assert property (blk_mode && tx_fifo_count >= depth_w |=>
        tx_dma_request_n_q)
        else $error("transmit request not high when full");

    a_rx_empty_high: assert property (blk_mode && rx_fifo_count == '0 && !events.rx_timeout |=>
        rx_dma_request_n_q)
        else $error("receive request not high when empty");

    a_single_rx: assert property (!blk_mode && rx_fifo_count != '0 |=> !rx_dma_request_n_q)
        else $error("single mode receive request wrong");

endmodule

`default_nettype wire

// ===== sim/ufc_partner.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side of the block: FIFO fill counters, transmit path state, event pulses
module ufc_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ufc_pkg::ufc_fcr_t fifo_control,
    input wire logic tx_set,
    input wire logic [6:0] tx_val,
    input wire logic rx_set,
    input wire logic [6:0] rx_val,
    input wire ufc_pkg::ufc_evt_t evt_cmd,
    output logic [6:0] tx_fifo_count,
    output logic [6:0] rx_fifo_count,
    output logic tx_path_empty,
    output ufc_pkg::ufc_evt_t events
);
    import ufc_pkg::*;

    logic [6:0] cap;

    // Capacity: holding register when off, else the selected depth
    assign cap = !fifo_control.enable ? 7'h01 : (fifo_control.depth64 ? 7'h40 : 7'h10);

    // Transmit fill; a flush pulse empties it at once
    always_ff @(posedge aclk) begin
        if (!aresetn || fifo_control.tx_fifo_flush) begin
            tx_fifo_count <= 7'h00;
        end else if (tx_set) begin
            tx_fifo_count <= (tx_val > cap) ? cap : tx_val;
        end
    end

    // Receive fill; a flush pulse empties it at once
    always_ff @(posedge aclk) begin
        if (!aresetn || fifo_control.rx_fifo_flush) begin
            rx_fifo_count <= 7'h00;
        end else if (rx_set) begin
            rx_fifo_count <= (rx_val > cap) ? cap : rx_val;
        end
    end

    // Nothing waits to be sent when the counter is empty
    assign tx_path_empty = (tx_fifo_count == 7'h00);

    // Events leave as one-cycle pulses
    always_ff @(posedge aclk) begin
        events <= aresetn ? evt_cmd : ufc_evt_t'(4'h0);
    end
endmodule
`default_nettype wire

// ===== sim/ufc_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ufc_top_tb_top;
    import ufc_pkg::*;

    localparam logic [1:0] OK = 2'h0;
    localparam logic [1:0] ER = 2'h2;
    localparam logic [7:0] ST = 8'h00;
    localparam logic [7:0] CT = 8'h04;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] tx_fifo_count, rx_fifo_count, rx_trigger_level_q, tx_val, rx_val, rv;
    logic tx_path_empty, tx_dma_request_n_q, rx_dma_request_n_q, tx_set, rx_set;
    ufc_evt_t events, evt_cmd;
    ufc_fcr_t fifo_control_q;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [6:0] trig [8] = '{7'h01, 7'h04, 7'h08, 7'h0E, 7'h01, 7'h10, 7'h20, 7'h38};

    ufc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tx_fifo_count, .rx_fifo_count, .tx_path_empty, .events, .fifo_control_q,
        .rx_trigger_level_q, .tx_dma_request_n_q, .rx_dma_request_n_q);

    ufc_partner u_far (.aclk, .aresetn, .fifo_control(fifo_control_q), .tx_set, .tx_val, .rx_set,
        .rx_val, .evt_cmd, .tx_fifo_count, .rx_fifo_count, .tx_path_empty, .events);

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus master; expectations go to the queues
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        bq.push_back(er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
        rq.push_back({r, 24'h000000, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask

    // Far side commands
    task automatic setc(input logic [6:0] t, input logic [6:0] r);
        @(posedge aclk);
        tx_val <= t;
        rx_val <= r;
        tx_set <= 1'h1;
        rx_set <= 1'h1;
        @(posedge aclk);
        tx_set <= 1'h0;
        rx_set <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic fire(input logic [3:0] e);
        @(posedge aclk);
        evt_cmd <= ufc_evt_t'(e);
        @(posedge aclk);
        evt_cmd <= ufc_evt_t'(4'h0);
        repeat (2) @(posedge aclk);
    endtask

    // Let the far side and the request flops settle before looking
    task automatic pins(input logic t, input logic r);
        repeat (2) @(negedge aclk);
        chk("tx_req", 34'(tx_dma_request_n_q), 34'(t));
        chk("rx_req", 34'(rx_dma_request_n_q), 34'(r));
    endtask

    // Response watcher takes the oldest expectation
    always @(posedge aclk) begin
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            chk("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
        end
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {tx_set, rx_set, tx_val, rx_val} = 16'h0;
        evt_cmd = ufc_evt_t'(4'h0);
        void'($urandom(32'h9e93));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        chk("ctrl", 34'(fifo_control_q), 34'h0);
        chk("trig", 34'(rx_trigger_level_q), 34'h1);
        pins(1'h0, 1'h1);
        rd(ST, 8'h01, OK);
        rd(CT, 8'h00, OK);
        wr(CT, 8'hFE, OK);
        rd(CT, 8'h00, OK);
        wr(ST, 8'hFF, OK);
        rd(ST, 8'h01, OK);
        wr(8'h08, 8'h01, ER);
        rd(8'h05, 8'h00, ER);
        rd(CT, 8'h00, OK);
        for (int i = 0; i < 8; i++) begin
            wr(CT, {i[1:0], i[2], 5'h01}, OK);
            @(negedge aclk);
            chk("trig", 34'(rx_trigger_level_q), 34'(trig[i]));
            rd(ST, {2'h3, i[2], 5'h01}, OK);
            rd(CT, {i[1:0], i[2], 5'h01}, OK);
        end
        wr(CT, 8'h01, OK);
        fire(4'hF);
        rd(ST, 8'hC6, OK);
        rd(ST, 8'hCC, OK);
        rd(ST, 8'hC2, OK);
        rd(ST, 8'hC0, OK);
        rd(ST, 8'hC1, OK);
        setc(7'h00, 7'h01);
        rd(ST, 8'hC4, OK);
        pins(1'h0, 1'h0);
        wr(CT, 8'h03, OK);
        rd(ST, 8'hC1, OK);
        rd(CT, 8'h01, OK);
        // Low byte not strobed: the control register must not move
        s_axi_wstrb <= 4'hE;
        wr(CT, 8'h00, OK);
        s_axi_wstrb <= 4'hF;
        rd(CT, 8'h01, OK);
        rv = 7'(1 + $urandom % 15);
        setc(rv, rv);
        pins(1'h1, 1'h0);
        wr(CT, 8'h07, OK);
        pins(1'h0, 1'h1);
        wr(CT, 8'h09, OK);
        setc(7'h10, 7'h00);
        pins(1'h1, 1'h1);
        setc(7'h0C, 7'h00);
        pins(1'h1, 1'h1);
        setc(7'h08, 7'h00);
        pins(1'h0, 1'h1);
        setc(7'h10, 7'h01);
        pins(1'h1, 1'h0);
        wr(CT, 8'h4F, OK);
        pins(1'h0, 1'h1);
        setc(7'h00, 7'h02);
        pins(1'h0, 1'h1);
        fire(4'h4);
        pins(1'h0, 1'h0);
        setc(7'h00, 7'h00);
        pins(1'h0, 1'h1);
        wr(CT, 8'h00, OK);
        rd(CT, 8'h48, OK);
        rd(ST, 8'h0C, OK);
        rd(ST, 8'h01, OK);
        repeat (4) @(posedge aclk);
        give_verdict();
    end
endmodule
`default_nettype wire
